/* File: src/cfid_regs.svh */
/*
 * offsets, field positions, field values and reset values of the core
 * feature identification bank; included by the package, cfid_values, cfid_bank and the bench.
 * assumes 32-bit apb data with one aligned word per register.
 */
`ifndef CFID_REGS_SVH
`define CFID_REGS_SVH

// ----------------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------------
`define CFID_OFF_MMFR2_LO   12'h000
`define CFID_OFF_MMFR2_HI   12'h004
`define CFID_OFF_PFR0_LO    12'h008
`define CFID_OFF_PFR0_HI    12'h00c
`define CFID_OFF_PFR1_LO    12'h010
`define CFID_OFF_PFR1_HI    12'h014
`define CFID_OFF_AFR32      12'h018
`define CFID_OFF_DFR32      12'h01c
`define CFID_OFF_ISAR0      12'h020
`define CFID_OFF_CTRL       12'h024
`define CFID_OFF_STAT       12'h028

// ----------------------------------------------------------------------
// memory model feature 2 (64 bit)
// ----------------------------------------------------------------------
`define CFID_MM2_ATOM_LSB   32
`define CFID_MM2_ATOM_VAL   4'h1
`define CFID_MM2_VAR_LSB    16
`define CFID_MM2_VAR_VAL    4'h0
`define CFID_MM2_IEB_LSB    12
`define CFID_MM2_IEB_VAL    4'h1
`define CFID_MM2_LSO_LSB    8
`define CFID_MM2_LSO_VAL    4'h0
`define CFID_MM2_USRO_LSB   4
`define CFID_MM2_USRO_VAL   4'h1
`define CFID_MM2_CTB_LSB    0
`define CFID_MM2_CTB_VAL    4'h1

// ----------------------------------------------------------------------
// processor feature 0 and 1 (64 bit)
// ----------------------------------------------------------------------
`define CFID_PF0_FLS_LSB    60
`define CFID_PF0_FLS_RST    4'h1
`define CFID_PF0_BRI_LSB    56
`define CFID_PF0_BRI_RST    4'h1
`define CFID_PF0_REL_LSB    28
`define CFID_PF0_REL_VAL    4'h1
`define CFID_PF0_IRQ_LSB    24
`define CFID_PF0_IRQ_VAL    4'h1
`define CFID_PF0_VEC_LSB    20
`define CFID_PF0_FPU_LSB    16
`define CFID_PF0_VEC_VAL    4'h1
`define CFID_PF0_EL3_LSB    12
`define CFID_PF0_EL2_LSB    8
`define CFID_PF0_EL1_LSB    4
`define CFID_PF0_ELX_VAL    4'h1
`define CFID_PF0_EL0_LSB    0
`define CFID_PF0_EL0_VAL    4'h2
`define CFID_PF1_SBS_LSB    4
`define CFID_PF1_SBS_VAL    4'h1

// ----------------------------------------------------------------------
// debug feature and instruction attribute 0 (32 bit)
// ----------------------------------------------------------------------
`define CFID_DF_PMU_LSB     24
`define CFID_DF_PMU_VAL     4'h4
`define CFID_DF_MTR_LSB     16
`define CFID_DF_MTR_VAL     4'h1
`define CFID_DF_CTR_LSB     12
`define CFID_DF_CTR_VAL     4'h0
`define CFID_DF_CSD_LSB     4
`define CFID_DF_CDB_LSB     0
`define CFID_DF_DBG_VAL     4'h8
`define CFID_IS_DIV_LSB     24
`define CFID_IS_DIV_VAL     4'h2
`define CFID_IS_BKP_LSB     20
`define CFID_IS_CBR_LSB     12
`define CFID_IS_BFO_LSB     8
`define CFID_IS_BCN_LSB     4
`define CFID_IS_ONE_VAL     4'h1
`define CFID_IS_SWP_LSB     0
`define CFID_IS_SWP_VAL     4'h0

// ----------------------------------------------------------------------
// own control and status bits
// ----------------------------------------------------------------------
`define CFID_CTRL_HOLD_BIT  0
`define CFID_STAT_DIS_BIT   0
`define CFID_STAT_ROW_BIT   1
`define CFID_CTRL_RST       1'b0

`endif

/* File: src/cfid_pkg.sv */
/*
 * types of the core feature identification bank.
 * assumes cfid_regs.svh is on the include path.
 */
package cfid_pkg;
    `include "cfid_regs.svh"

    typedef enum logic [3:0] {
        CFID_R_MM2_LO = 4'h0,
        CFID_R_MM2_HI = 4'h1,
        CFID_R_PF0_LO = 4'h2,
        CFID_R_PF0_HI = 4'h3,
        CFID_R_PF1_LO = 4'h4,
        CFID_R_PF1_HI = 4'h5,
        CFID_R_AFR    = 4'h6,
        CFID_R_DFR    = 4'h7,
        CFID_R_ISAR   = 4'h8,
        CFID_R_CTRL   = 4'h9,
        CFID_R_STAT   = 4'ha,
        CFID_R_NONE   = 4'hf
    } cfid_reg_t;

    // every identification word as seen by software
    typedef struct packed {
        logic [63:0] memory_model_feature_2;
        logic [63:0] processor_feature_0;
        logic [63:0] processor_feature_1;
        logic [31:0] auxiliary_feature_32bit;
        logic [31:0] debug_feature_32bit;
        logic [31:0] instruction_set_attr_0;
    } cfid_words_t;

    // registered state of the top module, apart from the flip-flops of the synchroniser
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        hold_en;
        logic        held_dis;
        logic        ro_write_seen;
    } cfid_state_t;
endpackage

/* File: src/cfid_sync.sv */
/*
 * two flip-flop synchroniser for one level from outside the pclk domain.
 * assumes the level is slow next to pclk; no pulse is guaranteed.
 */
`timescale 1ns/1ns
module cfid_sync
    import cfid_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    typedef struct packed {
        logic meta;
        logic stable;
    } cfid_sync_t;

    cfid_sync_t st_r;
    cfid_sync_t st_nxt;

    always_comb
    begin
        st_nxt.meta   = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sync_out = st_r.stable;
endmodule

/* File: src/cfid_values.sv */
/*
 * builds every identification word from build options and the effective
 * interrupt interface disable level; purely combinational.
 * assumes irq_dis is already in the pclk domain.
 */
`timescale 1ns/1ns
`include "cfid_regs.svh"
module cfid_values
    import cfid_pkg::*;
#(
    parameter bit ECC_PRESENT    = 1'b1,
    parameter bit IRQ_IF_PRESENT = 1'b1,
    parameter bit HAS_32BIT      = 1'b1
)
(
    // effective disable level
    input  wire logic  irq_dis,
    // identification words
    output cfid_words_t words
);
    always_comb
    begin
        words = '0;  // reserved fields stay zero [R23]
        words.memory_model_feature_2[`CFID_MM2_ATOM_LSB +: 4] = `CFID_MM2_ATOM_VAL; // [R1]
        words.memory_model_feature_2[`CFID_MM2_VAR_LSB +: 4]  = `CFID_MM2_VAR_VAL;  // [R2]
        words.memory_model_feature_2[`CFID_MM2_IEB_LSB +: 4]  = `CFID_MM2_IEB_VAL;  // [R3]
        words.memory_model_feature_2[`CFID_MM2_LSO_LSB +: 4]  = `CFID_MM2_LSO_VAL;  // [R4]
        words.memory_model_feature_2[`CFID_MM2_USRO_LSB +: 4] = `CFID_MM2_USRO_VAL; // [R5]
        words.memory_model_feature_2[`CFID_MM2_CTB_LSB +: 4]  = `CFID_MM2_CTB_VAL;  // [R6]
        words.processor_feature_0[`CFID_PF0_FLS_LSB +: 4] = `CFID_PF0_FLS_RST;     // [R7]
        words.processor_feature_0[`CFID_PF0_BRI_LSB +: 4] = `CFID_PF0_BRI_RST;     // [R8]
        if (ECC_PRESENT)
            words.processor_feature_0[`CFID_PF0_REL_LSB +: 4] = `CFID_PF0_REL_VAL; // [R9]
        if (IRQ_IF_PRESENT && !irq_dis)
            words.processor_feature_0[`CFID_PF0_IRQ_LSB +: 4] = `CFID_PF0_IRQ_VAL; // [R10]
        words.processor_feature_0[`CFID_PF0_VEC_LSB +: 4] = `CFID_PF0_VEC_VAL;     // [R11]
        words.processor_feature_0[`CFID_PF0_FPU_LSB +: 4] = `CFID_PF0_VEC_VAL;     // [R11]
        words.processor_feature_0[`CFID_PF0_EL3_LSB +: 4] = `CFID_PF0_ELX_VAL;     // [R12]
        words.processor_feature_0[`CFID_PF0_EL2_LSB +: 4] = `CFID_PF0_ELX_VAL;     // [R12]
        words.processor_feature_0[`CFID_PF0_EL1_LSB +: 4] = `CFID_PF0_ELX_VAL;     // [R12]
        words.processor_feature_0[`CFID_PF0_EL0_LSB +: 4] = `CFID_PF0_EL0_VAL;     // [R13]
        words.processor_feature_1[`CFID_PF1_SBS_LSB +: 4] = `CFID_PF1_SBS_VAL;     // [R14]
        // auxiliary word stays all zero [R15]
        words.debug_feature_32bit[`CFID_DF_PMU_LSB +: 4] = `CFID_DF_PMU_VAL;       // [R16]
        words.debug_feature_32bit[`CFID_DF_MTR_LSB +: 4] = `CFID_DF_MTR_VAL;       // [R17]
        words.debug_feature_32bit[`CFID_DF_CTR_LSB +: 4] = `CFID_DF_CTR_VAL;       // [R17]
        words.debug_feature_32bit[`CFID_DF_CSD_LSB +: 4] = `CFID_DF_DBG_VAL;       // [R18]
        words.debug_feature_32bit[`CFID_DF_CDB_LSB +: 4] = `CFID_DF_DBG_VAL;       // [R18]
        // without the 32-bit state the word has no meaning; zero is returned [R22]
        if (HAS_32BIT)
        begin
            words.instruction_set_attr_0[`CFID_IS_DIV_LSB +: 4] = `CFID_IS_DIV_VAL; // [R19]
            words.instruction_set_attr_0[`CFID_IS_BKP_LSB +: 4] = `CFID_IS_ONE_VAL; // [R20]
            words.instruction_set_attr_0[`CFID_IS_CBR_LSB +: 4] = `CFID_IS_ONE_VAL; // [R20]
            words.instruction_set_attr_0[`CFID_IS_BFO_LSB +: 4] = `CFID_IS_ONE_VAL; // [R20]
            words.instruction_set_attr_0[`CFID_IS_BCN_LSB +: 4] = `CFID_IS_ONE_VAL; // [R20]
            words.instruction_set_attr_0[`CFID_IS_SWP_LSB +: 4] = `CFID_IS_SWP_VAL; // [R21]
        end
    end
endmodule

/* File: src/cfid_bank.sv */
/*
 * core feature identification register bank behind an apb slave.
 * assumes an apb master on pclk; irq_cpu_if_disable_input is an
 * asynchronous pin and is synchronised here.
 */
// What this block does
// R1: memory model 2 is read-only; atomicity field [35:32] reads one.
// R2: virtual range field [19:16] of memory model 2 reads zero.
// R3: implicit error barrier field [15:12] of memory model 2 reads one.
// R4: multi load/store ordering field [11:8] of memory model 2 reads zero.
// R5: user access override field [7:4] of memory model 2 reads one.
// R6: common translation field [3:0] of memory model 2 reads one.
// R7: faulting load safety field [63:60] of feature 0 resets to one.
// R8: branch isolation field [59:56] of feature 0 resets to one.
// R9: reliability field [31:28] reads one with error correction, else zero.
// R10: interrupt interface field [27:24] reads one only if present and enabled.
// R11: vector [23:20] and floating-point [19:16] fields of feature 0 read one.
// R12: exception level 3, 2 and 1 fields of feature 0 read one.
// R13: exception level 0 field [3:0] of feature 0 reads two.
// R14: store bypass safe field [7:4] of feature 1 reads one.
// R15: auxiliary 32-bit feature word is read-only and all reserved.
// R16: performance monitor field [27:24] of debug word reads four.
// R17: debug word reports mapped trace [19:16], no coprocessor trace [15:12].
// R18: both coprocessor debug fields of the debug word read eight.
// R19: divide field [27:24] of attribute 0 reads two.
// R20: breakpoint, compare-branch, bit-field and bit-count fields read one.
// R21: swap field [3:0] of attribute 0 reads zero.
// R22: without the 32-bit state attribute 0 has no meaning and reads zero.
// R23: reserved fields read zero; writes leave identification words unchanged.
`timescale 1ns/1ns
`include "cfid_regs.svh"
module cfid_bank
    import cfid_pkg::*;
#(
    parameter bit ECC_PRESENT    = 1'b1,
    parameter bit IRQ_IF_PRESENT = 1'b1,
    parameter bit HAS_32BIT      = 1'b1
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // core interface pin
    input  wire logic        irq_cpu_if_disable_input
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic cfid_reg_t cfid_decode(input logic [11:0] addr);
        case (addr)
            `CFID_OFF_MMFR2_LO: cfid_decode = CFID_R_MM2_LO;
            `CFID_OFF_MMFR2_HI: cfid_decode = CFID_R_MM2_HI;
            `CFID_OFF_PFR0_LO:  cfid_decode = CFID_R_PF0_LO;
            `CFID_OFF_PFR0_HI:  cfid_decode = CFID_R_PF0_HI;
            `CFID_OFF_PFR1_LO:  cfid_decode = CFID_R_PF1_LO;
            `CFID_OFF_PFR1_HI:  cfid_decode = CFID_R_PF1_HI;
            `CFID_OFF_AFR32:    cfid_decode = CFID_R_AFR;
            `CFID_OFF_DFR32:    cfid_decode = CFID_R_DFR;
            `CFID_OFF_ISAR0:    cfid_decode = CFID_R_ISAR;
            `CFID_OFF_CTRL:     cfid_decode = CFID_R_CTRL;
            `CFID_OFF_STAT:     cfid_decode = CFID_R_STAT;
            default:            cfid_decode = CFID_R_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // disable pin and identification words
    // ------------------------------------------------------------------
    cfid_state_t st_r;
    cfid_state_t st_nxt;
    cfid_words_t words;
    logic        dis_sync;
    logic        eff_dis;

    cfid_sync u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (irq_cpu_if_disable_input),
        .sync_out (dis_sync)
    );

    // hold lets software freeze the reported interrupt interface state
    assign eff_dis = st_r.hold_en ? st_r.held_dis : dis_sync;

    cfid_values #(
        .ECC_PRESENT    (ECC_PRESENT),
        .IRQ_IF_PRESENT (IRQ_IF_PRESENT),
        .HAS_32BIT      (HAS_32BIT)
    ) u_values
    (
        .irq_dis (eff_dis),
        .words   (words)
    );

    // ------------------------------------------------------------------
    // apb access
    // ------------------------------------------------------------------
    logic      setup;
    logic      wr_done;
    cfid_reg_t sel_reg;
    logic      id_reg;

    assign setup   = psel && !penable;
    assign wr_done = psel && penable && st_r.pready && pwrite;
    assign sel_reg = cfid_decode(paddr);
    assign id_reg  = (sel_reg != CFID_R_NONE) && (sel_reg != CFID_R_CTRL)
                     && (sel_reg != CFID_R_STAT);

    always_comb
    begin
        st_nxt        = st_r;
        // zero wait states: ready rises for the access phase only
        st_nxt.pready = setup;
        if (!st_r.hold_en)
            st_nxt.held_dis = dis_sync;
        if (setup)
        begin
            st_nxt.pslverr = (sel_reg == CFID_R_NONE);
            st_nxt.prdata  = '0;
            if (!pwrite)
            begin
                case (sel_reg)
                    CFID_R_MM2_LO: st_nxt.prdata = words.memory_model_feature_2[31:0];
                    CFID_R_MM2_HI: st_nxt.prdata = words.memory_model_feature_2[63:32];
                    CFID_R_PF0_LO: st_nxt.prdata = words.processor_feature_0[31:0];
                    CFID_R_PF0_HI: st_nxt.prdata = words.processor_feature_0[63:32];
                    CFID_R_PF1_LO: st_nxt.prdata = words.processor_feature_1[31:0];
                    CFID_R_PF1_HI: st_nxt.prdata = words.processor_feature_1[63:32];
                    CFID_R_AFR:    st_nxt.prdata = words.auxiliary_feature_32bit;  // [R15]
                    CFID_R_DFR:    st_nxt.prdata = words.debug_feature_32bit;
                    CFID_R_ISAR:   st_nxt.prdata = words.instruction_set_attr_0;
                    CFID_R_CTRL:   st_nxt.prdata[`CFID_CTRL_HOLD_BIT] = st_r.hold_en;
                    CFID_R_STAT:
                    begin
                        st_nxt.prdata[`CFID_STAT_DIS_BIT] = dis_sync;
                        st_nxt.prdata[`CFID_STAT_ROW_BIT] = st_r.ro_write_seen;
                    end
                    default:       st_nxt.prdata = '0;
                endcase
            end
        end
        else
        begin
            st_nxt.pslverr = 1'b0;
        end
        if (wr_done && pstrb[0] && sel_reg == CFID_R_CTRL)
            st_nxt.hold_en = pwdata[`CFID_CTRL_HOLD_BIT];
        // a fresh write attempt beats a clear in the same cycle
        if (wr_done && pstrb[0] && sel_reg == CFID_R_STAT && pwdata[`CFID_STAT_ROW_BIT])
            st_nxt.ro_write_seen = 1'b0;
        if (wr_done && id_reg)
            st_nxt.ro_write_seen = 1'b1;  // contents untouched, only noted [R23]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r         <= '0;
            st_r.hold_en <= `CFID_CTRL_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata  = st_r.prdata;
    assign pready  = st_r.pready;
    assign pslverr = st_r.pslverr;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic rd_setup;
    assign rd_setup = setup && !pwrite;

    property p_mm2_hi;
        rd_setup && sel_reg == CFID_R_MM2_HI |=>
            prdata == 32'h0000_0001 && pready;
    endproperty
    a_mm2_hi: assert property (p_mm2_hi) // [R1] [R23]
        else $error("memory model 2 upper word wrong");

    property p_mm2_lo;
        rd_setup && sel_reg == CFID_R_MM2_LO |=>
            prdata[19:16] == 4'h0 && prdata[15:12] == 4'h1 && prdata[11:8] == 4'h0
            && prdata[7:4] == 4'h1 && prdata[3:0] == 4'h1 && prdata[31:20] == 12'h000;
    endproperty
    a_mm2_lo: assert property (p_mm2_lo) // [R2] [R3] [R4] [R5] [R6]
        else $error("memory model 2 lower word wrong");

    property p_pf0_hi;
        rd_setup && sel_reg == CFID_R_PF0_HI |=> prdata == 32'h1100_0000;
    endproperty
    a_pf0_hi: assert property (p_pf0_hi) // [R7] [R8]
        else $error("speculation safety fields wrong");

    property p_pf0_rel;
        rd_setup && sel_reg == CFID_R_PF0_LO |=>
            prdata[31:28] == (ECC_PRESENT ? 4'h1 : 4'h0);
    endproperty
    a_pf0_rel: assert property (p_pf0_rel) // [R9]
        else $error("reliability field disagrees with build");

    property p_pf0_irq;
        rd_setup && sel_reg == CFID_R_PF0_LO |=>
            prdata[27:24] == {3'b000, IRQ_IF_PRESENT && !$past(eff_dis)};
    endproperty
    a_pf0_irq: assert property (p_pf0_irq) // [R10]
        else $error("interrupt interface field disagrees with disable");

    property p_pf0_levels;
        rd_setup && sel_reg == CFID_R_PF0_LO |=>
            prdata[23:0] == 24'h11_1112;
    endproperty
    a_pf0_levels: assert property (p_pf0_levels) // [R11] [R12] [R13]
        else $error("feature 0 lower fields wrong");

    property p_pf1;
        rd_setup && (sel_reg == CFID_R_PF1_LO || sel_reg == CFID_R_PF1_HI) |=>
            prdata == (($past(sel_reg) == CFID_R_PF1_LO) ? 32'h0000_0010 : 32'h0);
    endproperty
    a_pf1: assert property (p_pf1) // [R14]
        else $error("feature 1 wrong");

    property p_afr;
        rd_setup && sel_reg == CFID_R_AFR |=> prdata == 32'h0 && !pslverr;
    endproperty
    a_afr: assert property (p_afr) // [R15]
        else $error("auxiliary word not zero");

    property p_dfr;
        rd_setup && sel_reg == CFID_R_DFR |=> prdata == 32'h0401_0088;
    endproperty
    a_dfr: assert property (p_dfr) // [R16] [R17] [R18]
        else $error("debug word wrong");

    property p_isar;
        rd_setup && sel_reg == CFID_R_ISAR |=>
            prdata == (HAS_32BIT ? 32'h0210_1110 : 32'h0);
    endproperty
    a_isar: assert property (p_isar) // [R19] [R20] [R21] [R22]
        else $error("attribute 0 wrong");

    property p_ro_write;
        wr_done && id_reg |=> st_r.ro_write_seen ##1 (st_r.ro_write_seen || $past(wr_done));
    endproperty
    a_ro_write: assert property (p_ro_write) // [R23]
        else $error("write to read-only word not noted");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held for more than one cycle");

    property p_unmapped;
        setup && sel_reg == CFID_R_NONE |=> pslverr && pready && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address not refused");

    property p_ready_setup;
        setup |=> pready;
    endproperty
    a_ready_setup: assert property (p_ready_setup)
        else $error("no ready after setup");

    property p_ready_idle;
        !setup |=> !pready;
    endproperty
    a_ready_idle: assert property (p_ready_idle)
        else $error("ready without setup");

    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error outside the access cycle");

    property p_err_data;
        pslverr |-> prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data)
        else $error("refused access returned data");

    property p_rdata_hold;
        !setup |=> $stable(prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without setup");

    property p_write_zero;
        setup && pwrite |=> prdata == 32'h0;
    endproperty
    a_write_zero: assert property (p_write_zero)
        else $error("write returned data");

    property p_ctrl_read;
        rd_setup && sel_reg == CFID_R_CTRL |=> prdata == {31'h0, $past(st_r.hold_en)};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control read wrong");

    property p_stat_read;
        rd_setup && sel_reg == CFID_R_STAT |=>
            prdata == {30'h0, $past(st_r.ro_write_seen), $past(dis_sync)};
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status read wrong");

    property p_hold_write;
        wr_done && pstrb[0] && sel_reg == CFID_R_CTRL |=>
            st_r.hold_en == $past(pwdata[`CFID_CTRL_HOLD_BIT]);
    endproperty
    a_hold_write: assert property (p_hold_write)
        else $error("hold bit not written");

    property p_hold_keep;
        st_r.hold_en && !wr_done |=> $stable(eff_dis);
    endproperty
    a_hold_keep: assert property (p_hold_keep) // [R10]
        else $error("held disable level moved");

    property p_follow_pin;
        !st_r.hold_en |-> eff_dis == dis_sync;
    endproperty
    a_follow_pin: assert property (p_follow_pin) // [R10]
        else $error("disable level not live");

    property p_stat_clear;
        wr_done && pstrb[0] && sel_reg == CFID_R_STAT && pwdata[`CFID_STAT_ROW_BIT] |=>
            !st_r.ro_write_seen;
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("write flag not cleared");

    property p_words_fixed;
        wr_done && id_reg |=>
            words.memory_model_feature_2 == $past(words.memory_model_feature_2)
            && words.instruction_set_attr_0 == $past(words.instruction_set_attr_0);
    endproperty
    a_words_fixed: assert property (p_words_fixed) // [R1] [R23]
        else $error("write changed an identification word");
endmodule

/* File: verif/tb_cfid_bank.sv */
/*
 * self-checking bench for the core feature identification bank.
 * assumes the default build options and drives every port itself.
 */
`timescale 1ns/1ns
`include "cfid_regs.svh"
module tb_cfid_bank
    import cfid_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_pin;
    logic [31:0] rd;
    logic        er;
    int          fails;
    int          n_checks;
    int          seed;
    int          idx;

    cfid_bank i_cfid_bank
    (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .psel                     (psel),
        .penable                  (penable),
        .pwrite                   (pwrite),
        .paddr                    (paddr),
        .pwdata                   (pwdata),
        .pstrb                    (pstrb),
        .prdata                   (prdata),
        .pready                   (pready),
        .pslverr                  (pslverr),
        .irq_cpu_if_disable_input (irq_pin)
    );

    always #2 pclk = ~pclk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            $display("[FAIL] %0t no pready", $time);
            fails++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // identification words as software must see them
    function automatic logic [31:0] exp_word(input int i, input logic dis);
        case (i)
            0:       return 32'h00001011;
            1:       return 32'h00000001;
            2:       return {4'h1, 3'h0, ~dis, 24'h111112};
            3:       return 32'h11000000;
            4:       return 32'h00000010;
            7:       return 32'h04010088;
            8:       return 32'h02101110;
            default: return 32'h00000000;
        endcase
    endfunction

    task automatic read_all(input logic dis);
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, exp_word(i, dis));
            chk({31'h0, er}, 32'h0);
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        irq_pin = 1'b0;
        fails = 0;
        n_checks = 0;
        seed = 32'h70c44923;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        read_all(1'b0);
        apb(1'b0, `CFID_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `CFID_OFF_STAT, 32'h0);
        chk(rd, 32'h0);
        // random writes must not disturb any identification word
        repeat (20)
        begin
            idx = {$random(seed)} % 9;
            apb(1'b1, 12'(idx * 4), $random(seed));
            chk({31'h0, er}, 32'h0);
        end
        read_all(1'b0);
        apb(1'b0, `CFID_OFF_STAT, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, `CFID_OFF_STAT, 32'h2);
        apb(1'b0, `CFID_OFF_STAT, 32'h0);
        chk(rd, 32'h0);
        // unmapped space answers with an error and zero data
        repeat (8)
        begin
            idx = {$random(seed)} % 1000;
            apb(1'($random(seed)), 12'h02c + 12'(idx * 4), $random(seed));
            chk({31'h0, er}, 32'h1);
            chk(rd, 32'h0);
        end
        irq_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        read_all(1'b1);
        apb(1'b0, `CFID_OFF_STAT, 32'h0);
        chk(rd, 32'h1);
        // hold freezes the reported level while the pin moves
        apb(1'b1, `CFID_OFF_CTRL, 32'h1);
        irq_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, `CFID_OFF_PFR0_LO, 32'h0);
        chk(rd, exp_word(2, 1'b1));
        // second reset clears the hold and exposes the live level
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, `CFID_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `CFID_OFF_PFR0_LO, 32'h0);
        chk(rd, exp_word(2, 1'b0));
        end_sim();
    end
endmodule
